// [osc_scan_cfg.sv]
/*
  Command interpreter for sleep, page, scan direction, offset, clock
  divide, oscillator trim and pre-charge/discharge periods.
  Assumes command and data bytes arrive as one-cycle strobes on MCLK_I.
*/
// Notes on behaviour
// - Display-off command enters sleep.
// - Asleep: oscillator and charge pump stop until display on, whose first display clock ends sleep.
// - Asleep: panel drivers released to high impedance.
// - Sleep keeps display memory and all settings unchanged.
// - Memory writes still accepted while asleep.
// - Bytes B0-B7 load page address 0 to 7.
// - Page address affects host access only, not the panel.
// - Bit 3 of C0-CF selects scan direction; normal at reset.
// - Scan direction change takes effect immediately.
// - Two-byte commands: mode byte then next command byte as parameter.
// - D3 data low six bits set start row offset, reset 0.
// - D5 low nibble plus one is divide ratio, reset 1.
// - D5 high nibble trims oscillator in 5 percent steps, reset 5.
// - Frame rate follows oscillator, ratio, clocks per row, mux.
// - D9 low nibble is pre-charge 1 to 15 clocks, reset 2.
// - D9 high nibble is discharge 1 to 15 clocks, reset 2.
// - Phases counted in whole divided display clocks.
// - Data byte writes memory then column advances by one.
`timescale 1ns/100ps
module osc_scan_cfg (
  input wire logic MCLK_I,
  input wire logic RST_I,
  input wire logic BYTE_VALID_I,
  input wire logic CMD_DATA_SELECT_I,
  input wire logic [7:0] BYTE_I,
  output logic ASLEEP_O,
  output logic OSC_RUN_O,
  output logic PUMP_RUN_O,
  output logic DRIVERS_OE_O,
  output logic DIVIDED_DISPLAY_CLOCK_TICK_O,
  output logic [2:0] PAGE_O,
  output logic [7:0] COLUMN_O,
  output logic SCAN_REVERSE_O,
  output logic [5:0] OFFSET_O,
  output logic [3:0] DIV_CODE_O,
  output logic [3:0] TRIM_CODE_O,
  output logic [3:0] PRE_CLKS_O,
  output logic [3:0] DIS_CLKS_O,
  output logic MEM_WE_O,
  output logic [2:0] MEM_PAGE_O,
  output logic [7:0] MEM_COL_O,
  output logic [7:0] MEM_DATA_O,
  output logic [1:0] PHASE_O
);

  // ****************************************************************
  // Command decode state
  // ****************************************************************
  osc_pkg::osc_state_type st_q;
  osc_pkg::osc_state_type st_d;
  logic asleep_q, asleep_d;
  logic osc_q, osc_d;
  logic [2:0] page_q, page_d;
  logic [7:0] col_q, col_d;
  logic scan_q, scan_d;
  logic [5:0] offs_q, offs_d;
  logic [3:0] div_q, div_d;
  logic [3:0] trim_q, trim_d;
  logic [3:0] pre_q, pre_d;
  logic [3:0] dis_q, dis_d;
  logic we_q, we_d;
  logic [2:0] wpage_q, wpage_d;
  logic [7:0] wcol_q, wcol_d;
  logic [7:0] wdata_q, wdata_d;
  logic cmd_v;
  logic data_v;
  logic divided_display_clock_tick;

  assign cmd_v = BYTE_VALID_I && !CMD_DATA_SELECT_I;
  assign data_v = BYTE_VALID_I && CMD_DATA_SELECT_I;

  // Decodes command bytes and parameters; settings never change on sleep.
  always_comb begin
    st_d = st_q;
    asleep_d = asleep_q;
    osc_d = osc_q;
    page_d = page_q;
    col_d = col_q;
    scan_d = scan_q;
    offs_d = offs_q;
    div_d = div_q;
    trim_d = trim_q;
    pre_d = pre_q;
    dis_d = dis_q;
    we_d = 1'b0;
    wpage_d = wpage_q;
    wcol_d = wcol_q;
    wdata_d = wdata_q;
    // Wake completes once the divided display clock delivers its first tick; a display-off
    // byte taken in the same cycle is decoded below and so still wins.
    if (asleep_q && osc_q && divided_display_clock_tick) begin
      asleep_d = 1'b0;
    end
    if (data_v) begin
      // Memory write works regardless of sleep.
      we_d = 1'b1;
      wpage_d = page_q;
      wcol_d = col_q;
      wdata_d = BYTE_I;
      col_d = col_q + 8'h01;
    end else if (cmd_v) begin
      case (st_q)
        osc_pkg::ST_OFFSET: begin
          offs_d = BYTE_I[osc_pkg::OFFSET_W-1:0];
          st_d = osc_pkg::ST_IDLE;
        end
        osc_pkg::ST_CLKDIV: begin
          div_d = BYTE_I[osc_pkg::NIB_W-1:0];
          trim_d = BYTE_I[7:osc_pkg::NIB_W];
          st_d = osc_pkg::ST_IDLE;
        end
        osc_pkg::ST_PERIOD: begin
          pre_d = BYTE_I[osc_pkg::NIB_W-1:0];
          dis_d = BYTE_I[7:osc_pkg::NIB_W];
          st_d = osc_pkg::ST_IDLE;
        end
        osc_pkg::ST_IDLE: begin
          if (BYTE_I == osc_pkg::CMD_DISP_OFF) begin
            asleep_d = 1'b1;
            osc_d = 1'b0;
          end else if (BYTE_I == osc_pkg::CMD_DISP_ON) begin
            osc_d = 1'b1;
          end else if ((BYTE_I & osc_pkg::CMD_PAGE_MASK) == osc_pkg::CMD_PAGE_BASE) begin
            page_d = BYTE_I[2:0];
          end else if ((BYTE_I & osc_pkg::CMD_SCAN_MASK) == osc_pkg::CMD_SCAN_BASE) begin
            scan_d = BYTE_I[osc_pkg::SCAN_DIR_BIT];
          end else if (BYTE_I == osc_pkg::CMD_OFFSET) begin
            st_d = osc_pkg::ST_OFFSET;
          end else if (BYTE_I == osc_pkg::CMD_CLKDIV) begin
            st_d = osc_pkg::ST_CLKDIV;
          end else if (BYTE_I == osc_pkg::CMD_PERIOD) begin
            st_d = osc_pkg::ST_PERIOD;
          end
        end
        default: begin
          st_d = osc_pkg::ST_IDLE;
        end
      endcase
    end
  end

  // Registers the decode state.
  always_ff @(posedge MCLK_I) begin
    if (RST_I) begin
      st_q <= osc_pkg::ST_IDLE;
      asleep_q <= 1'b1;
      osc_q <= 1'b0;
      page_q <= osc_pkg::PAGE_RST;
      col_q <= osc_pkg::COL_RST;
      scan_q <= 1'b0;
      offs_q <= osc_pkg::OFFSET_RST;
      div_q <= osc_pkg::DIV_RST;
      trim_q <= osc_pkg::TRIM_RST;
      pre_q <= osc_pkg::PRE_RST;
      dis_q <= osc_pkg::DIS_RST;
      we_q <= 1'b0;
      wpage_q <= 3'h0;
      wcol_q <= 8'h00;
      wdata_q <= 8'h00;
    end else begin
      st_q <= st_d;
      asleep_q <= asleep_d;
      osc_q <= osc_d;
      page_q <= page_d;
      col_q <= col_d;
      scan_q <= scan_d;
      offs_q <= offs_d;
      div_q <= div_d;
      trim_q <= trim_d;
      pre_q <= pre_d;
      dis_q <= dis_d;
      we_q <= we_d;
      wpage_q <= wpage_d;
      wcol_q <= wcol_d;
      wdata_q <= wdata_d;
    end
  end

  // ****************************************************************
  // Oscillator and display clock
  // ****************************************************************
  logic osc_tick;
  logic [7:0] osc_period;

  // A higher trim code shortens the modelled oscillator period.
  assign osc_period = osc_pkg::OSC_BASE_CYC + osc_pkg::OSC_TRIM_MID - {4'h0, trim_q};

  // Oscillator stops from display off until display on.
  osc_divider u_osc (
    .clk_i(MCLK_I),
    .rst_i(RST_I),
    .run_i(osc_q),
    .en_i(1'b1),
    .ratio_i(osc_period),
    .tick_o(osc_tick)
  );

  // Display clock divides the oscillator by the code plus one.
  osc_divider u_divided_display_clock (
    .clk_i(MCLK_I),
    .rst_i(RST_I),
    .run_i(osc_q),
    .en_i(osc_tick),
    .ratio_i({4'h0, div_q} + 8'h01),
    .tick_o(divided_display_clock_tick)
  );

  // ****************************************************************
  // Row phase sequencer: discharge, pre-charge, drive
  // ****************************************************************
  osc_pkg::osc_phase_type ph_q;
  osc_pkg::osc_phase_type ph_d;
  logic [3:0] pcnt_q, pcnt_d;

  // Each phase lasts a whole number of display clocks; the row rate
  // and so frame rate follow from oscillator, ratio and phase lengths.
  always_comb begin
    ph_d = ph_q;
    pcnt_d = pcnt_q;
    if (asleep_q) begin
      ph_d = osc_pkg::PH_DIS;
      pcnt_d = 4'h0;
    end else if (divided_display_clock_tick) begin
      pcnt_d = pcnt_q + 4'h1;
      case (ph_q)
        osc_pkg::PH_DIS: begin
          if (pcnt_q + 4'h1 >= dis_q) begin
            ph_d = osc_pkg::PH_PRE;
            pcnt_d = 4'h0;
          end
        end
        osc_pkg::PH_PRE: begin
          if (pcnt_q + 4'h1 >= pre_q) begin
            ph_d = osc_pkg::PH_DRIVE;
            pcnt_d = 4'h0;
          end
        end
        osc_pkg::PH_DRIVE: begin
          if (pcnt_q + 4'h1 >= osc_pkg::DRIVE_CLKS) begin
            ph_d = osc_pkg::PH_DIS;
            pcnt_d = 4'h0;
          end
        end
        default: begin
          ph_d = osc_pkg::PH_DIS;
          pcnt_d = 4'h0;
        end
      endcase
    end
  end

  // Registers the phase state.
  always_ff @(posedge MCLK_I) begin
    if (RST_I) begin
      ph_q <= osc_pkg::PH_DIS;
      pcnt_q <= 4'h0;
    end else begin
      ph_q <= ph_d;
      pcnt_q <= pcnt_d;
    end
  end

  // ****************************************************************
  // Outputs
  // ****************************************************************
  // Page and column feed only the host access path.
  assign ASLEEP_O = asleep_q;
  assign OSC_RUN_O = osc_q;
  assign PUMP_RUN_O = osc_q;
  assign DRIVERS_OE_O = !asleep_q;
  assign DIVIDED_DISPLAY_CLOCK_TICK_O = divided_display_clock_tick;
  assign PAGE_O = page_q;
  assign COLUMN_O = col_q;
  assign SCAN_REVERSE_O = scan_q;
  assign OFFSET_O = offs_q;
  assign DIV_CODE_O = div_q;
  assign TRIM_CODE_O = trim_q;
  assign PRE_CLKS_O = pre_q;
  assign DIS_CLKS_O = dis_q;
  assign MEM_WE_O = we_q;
  assign MEM_PAGE_O = wpage_q;
  assign MEM_COL_O = wcol_q;
  assign MEM_DATA_O = wdata_q;
  assign PHASE_O = ph_q;

  // ****************************************************************
  // Assertions
  // ****************************************************************
  a_sleep_entry: assert property (@(posedge MCLK_I) disable iff (RST_I)
    cmd_v && st_q == osc_pkg::ST_IDLE && BYTE_I == osc_pkg::CMD_DISP_OFF
    |=> ASLEEP_O && !OSC_RUN_O) else $error("display off did not sleep");
  a_no_divided_display_clock_sleep: assert property (@(posedge MCLK_I) disable iff (RST_I)
    !osc_q ##1 !osc_q |-> !divided_display_clock_tick) else $error("display clock while stopped");
  a_hiz_sleep: assert property (@(posedge MCLK_I) disable iff (RST_I)
    !OSC_RUN_O |-> !DRIVERS_OE_O) else $error("drivers enabled without clocks");
  a_settings_held: assert property (@(posedge MCLK_I) disable iff (RST_I)
    !cmd_v |=> $stable(offs_q) && $stable(div_q) && $stable(pre_q) && $stable(trim_q)
    && $stable(dis_q) && $stable(scan_q))
    else $error("setting changed without command");
  a_mem_write: assert property (@(posedge MCLK_I) disable iff (RST_I)
    data_v |=> MEM_WE_O && MEM_DATA_O == $past(BYTE_I) && COLUMN_O == $past(col_q) + 8'h01)
    else $error("memory write lost");
  a_page_load: assert property (@(posedge MCLK_I) disable iff (RST_I)
    cmd_v && st_q == osc_pkg::ST_IDLE && BYTE_I[7:3] == 5'h16
    |=> PAGE_O == $past(BYTE_I[2:0])) else $error("page not loaded");
  a_scan_dir: assert property (@(posedge MCLK_I) disable iff (RST_I)
    cmd_v && st_q == osc_pkg::ST_IDLE && BYTE_I[7:4] == 4'hC
    |=> SCAN_REVERSE_O == $past(BYTE_I[3])) else $error("scan direction not applied");
  a_offset_param: assert property (@(posedge MCLK_I) disable iff (RST_I)
    cmd_v && st_q == osc_pkg::ST_OFFSET
    |=> OFFSET_O == $past(BYTE_I[5:0]) && st_q == osc_pkg::ST_IDLE)
    else $error("offset parameter not taken");
  a_phase_hold: assert property (@(posedge MCLK_I) disable iff (RST_I)
    !ASLEEP_O && !divided_display_clock_tick |=> $stable(ph_q) && $stable(pcnt_q))
    else $error("phase moved without display clock");
  a_wake_order: assert property (@(posedge MCLK_I) disable iff (RST_I)
    $fell(ASLEEP_O) |-> OSC_RUN_O && $past(divided_display_clock_tick)) else $error("drive before clock");

endmodule // osc_scan_cfg

// [osc_pkg.sv]
/*
  Package for the scan timing command interpreter: command codes, field
  positions, reset values and cycle constants.
  Assumes nothing of its surroundings beyond a SystemVerilog compiler.
*/
package osc_pkg;

  // ****************************************************************
  // Command codes and masks
  // ****************************************************************
  localparam logic [7:0] CMD_DISP_OFF = 8'hAE;
  localparam logic [7:0] CMD_DISP_ON = 8'hAF;
  localparam logic [7:0] CMD_PAGE_BASE = 8'hB0;
  localparam logic [7:0] CMD_PAGE_MASK = 8'hF8;
  localparam logic [7:0] CMD_SCAN_BASE = 8'hC0;
  localparam logic [7:0] CMD_SCAN_MASK = 8'hF0;
  localparam logic [7:0] CMD_OFFSET = 8'hD3;
  localparam logic [7:0] CMD_CLKDIV = 8'hD5;
  localparam logic [7:0] CMD_PERIOD = 8'hD9;

  // ****************************************************************
  // Field positions
  // ****************************************************************
  localparam int SCAN_DIR_BIT = 3;
  localparam int OFFSET_W = 6;
  localparam int NIB_W = 4;

  // ****************************************************************
  // Reset values
  // ****************************************************************
  localparam logic [2:0] PAGE_RST = 3'h0;
  localparam logic [5:0] OFFSET_RST = 6'h00;
  localparam logic [3:0] DIV_RST = 4'h0;
  localparam logic [3:0] TRIM_RST = 4'h5;
  localparam logic [3:0] PRE_RST = 4'h2;
  localparam logic [3:0] DIS_RST = 4'h2;
  localparam logic [7:0] COL_RST = 8'h00;

  // ****************************************************************
  // Oscillator model: base period and trim midpoint, in system cycles
  // ****************************************************************
  localparam logic [7:0] OSC_BASE_CYC = 8'h14;
  localparam logic [7:0] OSC_TRIM_MID = 8'h05;

  // ****************************************************************
  // Interpreter states
  // ****************************************************************
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_OFFSET = 2'b01,
    ST_CLKDIV = 2'b10,
    ST_PERIOD = 2'b11
  } osc_state_type;

  // ****************************************************************
  // Phase sequencer states
  // ****************************************************************
  typedef enum logic [1:0] {
    PH_DIS = 2'b00,
    PH_PRE = 2'b01,
    PH_DRIVE = 2'b10
  } osc_phase_type;

  localparam logic [3:0] DRIVE_CLKS = 4'h8;

endpackage

// [osc_divider.sv]
/*
  Divider producing one-cycle enable pulses at a programmable ratio.
  Assumes the enable input is itself a one-cycle pulse train or level.
*/
`timescale 1ns/100ps
module osc_divider (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic run_i,
  input wire logic en_i,
  input wire logic [7:0] ratio_i,
  output logic tick_o
);
  logic [7:0] cnt_q;
  logic [7:0] cnt_d;
  logic tick_d;
  logic tick_q;

  // Counts enabled input cycles and pulses when the ratio is reached.
  always_comb begin
    cnt_d = cnt_q;
    tick_d = 1'b0;
    if (!run_i) begin
      cnt_d = 8'h00;
    end else if (en_i) begin
      if (cnt_q >= ratio_i - 8'h01) begin
        cnt_d = 8'h00;
        tick_d = 1'b1;
      end else begin
        cnt_d = cnt_q + 8'h01;
      end
    end
  end

  // Registers the count and pulse.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cnt_q <= 8'h00;
      tick_q <= 1'b0;
    end else begin
      cnt_q <= cnt_d;
      tick_q <= tick_d;
    end
  end

  assign tick_o = tick_q;

endmodule // osc_divider

// [osc_host_model.sv]
/*
  Host model issuing command and display data bytes as one-cycle strobes.
  Assumes a free-running clock shared with the interpreter.
*/
`timescale 1ns/100ps
module osc_host_model (
  input wire logic clk_i,
  output logic valid_o,
  output logic sel_o,
  output logic [7:0] byte_o
);
  // *****************************************************************
  // Byte driver
  // *****************************************************************
  bit pend;

  // Lines start idle with the strobe low.
  initial begin
    valid_o = 1'b0;
    sel_o = 1'b0;
    byte_o = 8'h00;
    pend = 1'b0;
  end

  // Sends one byte; a command outside the known set is issued only as a parameter.
  task automatic send(input logic sel, input logic [7:0] b);
    bit ok;
    ok = sel || pend || b inside {8'hAE, 8'hAF, [8'hB0:8'hB7], 8'hC0, 8'hC8,
      8'hD3, 8'hD5, 8'hD9};
    if (ok) begin
      if (!sel) begin
        pend = !pend && (b inside {8'hD3, 8'hD5, 8'hD9});
      end
      @(posedge clk_i);
      valid_o <= 1'b1;
      sel_o <= sel;
      byte_o <= b;
      @(posedge clk_i);
      valid_o <= 1'b0;
      sel_o <= ~sel;
      byte_o <= ~b; // Released lines show a changed value.
    end
  endtask
endmodule // osc_host_model

// [osc_scan_cfg_tb.sv]
/*
  Self-checking testbench for the scan timing command interpreter.
  Assumes the host model drives the byte strobe and the design's package.
*/
`timescale 1ns/100ps
module osc_scan_cfg_tb;
  // *****************************************************************
  // Clock, reset and instances
  // *****************************************************************
  logic mclk = 1'b0;
  logic rst = 1'b1;
  logic vld, sel, asleep, osc, pump, oe, tick, scan, we;
  logic [7:0] byt, col, mcol, mdat;
  logic [2:0] page, mpage;
  logic [5:0] offs;
  logic [3:0] divc, trim, pre, dis;
  logic [1:0] phase;
  int fail_count = 0;
  int num_checks = 0;

  // Free-running 100 MHz clock.
  always #5 mclk = ~mclk;

  osc_host_model host (.clk_i(mclk), .valid_o(vld), .sel_o(sel), .byte_o(byt));

  osc_scan_cfg dut (.MCLK_I(mclk), .RST_I(rst), .BYTE_VALID_I(vld),
    .CMD_DATA_SELECT_I(sel), .BYTE_I(byt), .ASLEEP_O(asleep), .OSC_RUN_O(osc),
    .PUMP_RUN_O(pump), .DRIVERS_OE_O(oe), .DIVIDED_DISPLAY_CLOCK_TICK_O(tick), .PAGE_O(page),
    .COLUMN_O(col), .SCAN_REVERSE_O(scan), .OFFSET_O(offs), .DIV_CODE_O(divc),
    .TRIM_CODE_O(trim), .PRE_CLKS_O(pre), .DIS_CLKS_O(dis), .MEM_WE_O(we),
    .MEM_PAGE_O(mpage), .MEM_COL_O(mcol), .MEM_DATA_O(mdat), .PHASE_O(phase));

  // *****************************************************************
  // Shared tasks
  // *****************************************************************
  // Compares one value and counts the outcome.
  task automatic chk(input string name, input logic [7:0] seen, input logic [7:0] exp);
    num_checks++;
    if (seen !== exp) begin
      fail_count++;
      $display("unexpected %s expected %h seen %h", name, exp, seen);
    end
  endtask

  // Sends a byte and lets the taking edge land.
  task automatic put(input logic s, input logic [7:0] b);
    host.send(s, b);
    #1;
  endtask

  // Cycles between two display clock ticks, bounded.
  task automatic gap(output int n);
    int i;
    n = 0;
    for (i = 0; i < 2000 && tick !== 1'b1; i++) @(posedge mclk) #1;
    @(posedge mclk) #1;
    for (n = 1; n < 2000 && tick !== 1'b1; n++) @(posedge mclk) #1;
    if (i >= 2000 || n >= 2000) begin
      fail_count++;
      results();
    end
  endtask

  // Settings that must survive sleep and wake.
  task automatic keep(input logic [7:0] o, input logic [7:0] d);
    chk("offset", 8'(offs), o);
    chk("div", {trim, divc}, d);
    chk("period", {dis, pre}, 8'hF1);
    chk("scan", 8'(scan), 8'h01);
  endtask

  // *****************************************************************
  // Scenarios
  // *****************************************************************
  // Power-on values before any command.
  task automatic t_reset;
    chk("asleep", {osc, pump, oe, asleep}, 8'h01);
    chk("page", 8'(page), 8'(osc_pkg::PAGE_RST));
    chk("scan", 8'(scan), 8'h00);
    chk("offset", 8'(offs), 8'h00);
    chk("div", {trim, divc}, 8'h50);
    chk("period", {dis, pre}, 8'h22);
    chk("phase", 8'(phase), 8'h00);
    $display("test reset done");
  endtask

  // Writes while asleep, column advance, data inside a two-byte command.
  task automatic t_mem;
    int i;
    for (i = 0; i < 3; i++) begin
      put(1'b1, 8'h5A + 8'(i));
      chk("we", 8'(we), 8'h01);
      chk("data", mdat, 8'h5A + 8'(i));
      chk("mcol", mcol, 8'(i));
      chk("col", col, 8'(i + 1));
    end
    put(1'b0, 8'hD3);
    put(1'b1, 8'h77);
    chk("we", 8'(we), 8'h01);
    put(1'b0, 8'hFF);
    chk("offset", 8'(offs), 8'h3F);
    put(1'b0, 8'hD3);
    put(1'b0, 8'h30);
    chk("offset", 8'(offs), 8'h30);
    $display("test memory done");
  endtask

  // All page codes; the panel side stays untouched.
  task automatic t_page;
    int i;
    for (i = 7; i >= 0; i--) begin
      put(1'b0, 8'hB0 + 8'(i));
      chk("page", 8'(page), 8'(i));
      chk("offset", 8'(offs), 8'h30);
      put(1'b1, 8'h11);
      chk("mpage", 8'(mpage), 8'(i));
    end
    $display("test page done");
  endtask

  // Wake, clock rate from divide ratio, scan flip while running.
  task automatic t_wake;
    int t0;
    int t1;
    put(1'b0, 8'hAF);
    chk("osc", {osc, pump, oe, asleep}, 8'h0D);
    gap(t0);
    @(posedge mclk) #1;
    chk("awake", {oe, asleep}, 8'h02);
    chk("t0", 8'(t0), osc_pkg::OSC_BASE_CYC);
    put(1'b0, 8'hD5);
    put(1'b0, 8'h51);
    gap(t1);
    chk("t1", 8'(t1), 8'(2 * osc_pkg::OSC_BASE_CYC));
    put(1'b0, 8'hD5);
    put(1'b0, 8'hA7);
    chk("div", {trim, divc}, 8'hA7);
    put(1'b0, 8'hD9);
    put(1'b0, 8'hF1);
    chk("period", {dis, pre}, 8'hF1);
    put(1'b0, 8'hC8);
    chk("scan", 8'(scan), 8'h01);
    chk("oe", 8'(oe), 8'h01);
    $display("test wake done");
  endtask

  // Phase order and lengths in display clocks, discharge 15 and pre-charge 1.
  task automatic t_phase;
    int i;
    int n;
    int seen;
    logic [1:0] last;
    logic [7:0] len;
    n = 0;
    seen = 0;
    last = phase;
    for (i = 0; i < 8000 && seen < 4; i++) begin
      @(posedge mclk) #1;
      if (phase !== last) begin
        len = (last == 2'h0) ? 8'h0F : (last == 2'h1) ? 8'h01 : 8'h08;
        if (seen > 0) begin
          chk("phase len", 8'(n), len);
        end
        chk("phase next", 8'(phase), (last == 2'h2) ? 8'h00 : 8'(last) + 8'h01);
        seen++;
        n = 0;
        last = phase;
      end
      n += int'(tick === 1'b1);
    end
    if (seen < 4) begin
      fail_count++;
      results();
    end
    $display("test phase done");
  endtask

  // Sleep halts clocks and drivers and keeps offset, divide, trim, period and scan.
  task automatic t_sleep;
    int i;
    int n;
    n = 0;
    put(1'b0, 8'hAE);
    chk("sleep", {osc, pump, oe, asleep}, 8'h01);
    for (i = 0; i < 200; i++) begin
      @(posedge mclk) #1;
      n += int'(tick === 1'b1);
    end
    chk("ticks", 8'(n), 8'h00);
    chk("phase", 8'(phase), 8'h00);
    keep(8'h30, 8'hA7);
    put(1'b0, 8'hAF);
    gap(n);
    chk("rewake", {oe, asleep}, 8'h02);
    chk("t2", 8'(n), 8'h78);
    keep(8'h30, 8'hA7);
    $display("test sleep done");
  endtask

  // *****************************************************************
  // Main sequence and verdict
  // *****************************************************************
  // Prints the counts and the verdict, then ends the run.
  task automatic results;
    $display("checks %0d mismatches %0d", num_checks, fail_count);
    if (fail_count == 0 && num_checks > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  // Reset for 16 cycles, then every scenario in turn.
  initial begin
    repeat (16) @(posedge mclk);
    rst <= 1'b0;
    @(posedge mclk) #1;
    t_reset();
    t_mem();
    t_page();
    t_wake();
    t_phase();
    t_sleep();
    results();
  end
endmodule // osc_scan_cfg_tb
